// ==== bfs_consts.vh ====
// Shared constants of the buck fault sequencer: register map, fields and timing.
`ifndef BFS_CONSTS_VH
`define BFS_CONSTS_VH

// ==========================================================================
// Timing
// ==========================================================================
`define BFS_CLK_HZ        50000000
`define BFS_UV_DELAY_US   1000
`define BFS_HICCUP_US     16000
`define BFS_UV_ARM_US     1500
`define BFS_PG_RISE_US    1000
`define BFS_PG_FALL_US    2
`define BFS_SS_US         700
`define BFS_US_TO_CYC(us) ((us) * (`BFS_CLK_HZ / 1000000))

// ==========================================================================
// Register map (byte addresses)
// ==========================================================================
`define BFS_ADDR_CTRL     12'h000
`define BFS_ADDR_STATUS   12'h004
`define BFS_ADDR_EVENT    12'h008
`define BFS_ADDR_MASK     12'h00c

// Control fields.
`define BFS_CTRL_ENABLE   0
`define BFS_CTRL_RESET    1'h1

// Event bits, shared by the event and mask registers.
`define BFS_EV_UV         0
`define BFS_EV_OV         1
`define BFS_EV_LOCKOUT    2
`define BFS_EV_THERMAL    3
`define BFS_EV_PG_RISE    4
`define BFS_EV_PG_FALL    5
`define BFS_EV_W          6

// Sequencer states.
`define BFS_ST_OFF        3'h0
`define BFS_ST_SOFT       3'h1
`define BFS_ST_RUN        3'h2
`define BFS_ST_OVHOLD     3'h3
`define BFS_ST_HICCUP     3'h4
`define BFS_ST_OVWAIT     3'h5

`endif

// ==== bfs_power_stage.sv ====
// Behavioural power stage: switches, inductor and zero-current detector.
module bfs_power_stage #(
   parameter int DECAY = 3
) (
   input  logic pclk,
   input  logic presetn,
   input  logic high_side_on,
   input  logic low_side_on,
   output logic zero_current
);
   timeunit 1ns;
   timeprecision 1ps;
   int decay;

   // ==========================================================================
   // Inductor current
   // Current builds while the high side conducts and reaches zero DECAY + 1 cycles into the low-side phase.
   // In forced continuous mode it keeps falling, so the detector stays high and must be ignored.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decay <= 0;
         zero_current <= 1'h0;
      end else if (high_side_on) begin
         decay <= 0;
         zero_current <= 1'h0;
      end else if (low_side_on && decay < DECAY) begin
         decay <= decay + 1;
      end else if (low_side_on) begin
         zero_current <= 1'h1;
      end
   end
endmodule

// ==== bfs_sequencer.v ====
// Protection and mode sequencer of a synchronous buck controller, with an APB register file.
//
// Decided for this implementation: the register addresses and register access over APB.
`include "bfs_consts.vh"
module bfs_sequencer #(
   parameter UV_DELAY_CYC = `BFS_US_TO_CYC(`BFS_UV_DELAY_US),
   parameter HICCUP_CYC   = `BFS_US_TO_CYC(`BFS_HICCUP_US),
   parameter UV_ARM_CYC   = `BFS_US_TO_CYC(`BFS_UV_ARM_US),
   parameter PG_RISE_CYC  = `BFS_US_TO_CYC(`BFS_PG_RISE_US),
   parameter PG_FALL_CYC  = `BFS_US_TO_CYC(`BFS_PG_FALL_US),
   parameter SS_CYC       = `BFS_US_TO_CYC(`BFS_SS_US)
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        fb_under,
   input  wire        fb_over,
   input  wire        supply_lockout,
   input  wire        over_temp,
   input  wire        zero_current,
   input  wire        on_request,
   input  wire        fb_in_window,
   input  wire        fb_out_window,
   input  wire        forced_continuous_conduction,
   output reg         high_side_on,
   output reg         low_side_on,
   output reg         output_in_range_flag,
   output reg         irq
);

   localparam TW = 24;

   // ==========================================================================
   // Declarations
   // ==========================================================================
   wire [8:0]          syn;
   wire                s_uv;
   wire                s_ov;
   wire                s_lock;
   wire                s_temp;
   wire                s_zc;
   wire                s_on;
   wire                s_inw;
   wire                s_outw;
   wire                s_forced_continuous_conduction;
   reg  [2:0]          state;
   reg  [2:0]          next_state;
   reg                 enable;
   reg  [`BFS_EV_W-1:0] event_bits;
   reg  [`BFS_EV_W-1:0] mask;
   reg  [`BFS_EV_W-1:0] ev_set;
   reg                 uv_armed;
   reg                 low_off_cycle;
   reg                 next_hs;
   reg                 next_ls;
   wire                fault_stop;
   wire                wr_en;
   wire                rd_en;
   wire                uv_done;
   wire                uv_run;
   wire                hic_done;
   wire                hic_run;
   wire                arm_done;
   wire                arm_run;
   wire                ss_done;
   wire                ss_run;
   wire                pgr_done;
   wire                pgr_run;
   wire                pgf_done;
   wire                pgf_run;
   wire                uv_seen;
   wire                ss_start;
   wire                leave_run;
   wire                uv_armed_pg;

   // Shrinks a 32-bit parameter to the timer width on purpose.
   function [TW-1:0] cyc;
      input integer n;
      begin
         cyc = n[TW-1:0];
      end
   endfunction

   // ==========================================================================
   // Input synchronisation
   // ==========================================================================
   // Every comparator flag passes two flops before any decision looks at it.
   bfs_sync #(.W(9)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({fb_under, fb_over, supply_lockout, over_temp, zero_current,
                  on_request, fb_in_window, fb_out_window, forced_continuous_conduction}),
      .sync_out (syn)
   );

   assign s_uv   = syn[8];
   assign s_ov   = syn[7];
   assign s_lock = syn[6];
   assign s_temp = syn[5];
   assign s_zc   = syn[4];
   assign s_on   = syn[3];
   assign s_inw  = syn[2];
   assign s_outw = syn[1];
   assign s_forced_continuous_conduction = syn[0];

   // Lockout, temperature and software disable are non-latching stops.
   assign fault_stop = s_lock | s_temp | !enable;
   assign ss_start   = (state == `BFS_ST_OFF) && !fault_stop && !s_ov;
   assign leave_run  = (next_state != `BFS_ST_RUN) && (state == `BFS_ST_RUN);
   assign uv_seen    = s_uv && uv_armed && (state == `BFS_ST_RUN);

   // ==========================================================================
   // Delay timers
   // ==========================================================================
   // Undervoltage delay restarts on each rising of the armed flag, stops when it clears.
   bfs_timer #(.W(TW)) u_uv (
      .pclk(pclk), .presetn(presetn),
      .load(uv_seen && !uv_run && !uv_done), .stop(!uv_seen),
      .count(cyc(UV_DELAY_CYC)), .running(uv_run), .done(uv_done)
   );

   bfs_timer #(.W(TW)) u_hic (
      .pclk(pclk), .presetn(presetn),
      .load((state != `BFS_ST_HICCUP) && (next_state == `BFS_ST_HICCUP)), .stop(fault_stop),
      .count(cyc(HICCUP_CYC)), .running(hic_run), .done(hic_done)
   );

   bfs_timer #(.W(TW)) u_ss (
      .pclk(pclk), .presetn(presetn),
      .load(ss_start), .stop(fault_stop),
      .count(cyc(SS_CYC)), .running(ss_run), .done(ss_done)
   );

   bfs_timer #(.W(TW)) u_arm (
      .pclk(pclk), .presetn(presetn),
      .load(ss_done), .stop(state != `BFS_ST_RUN),
      .count(cyc(UV_ARM_CYC)), .running(arm_run), .done(arm_done)
   );

   bfs_timer #(.W(TW)) u_pgr (
      .pclk(pclk), .presetn(presetn),
      .load(s_inw && !output_in_range_flag && !pgr_run && !pgr_done && uv_armed_pg),
      .stop(!s_inw || state != `BFS_ST_RUN),
      .count(cyc(PG_RISE_CYC)), .running(pgr_run), .done(pgr_done)
   );

   bfs_timer #(.W(TW)) u_pgf (
      .pclk(pclk), .presetn(presetn),
      .load(s_outw && output_in_range_flag && !pgf_run && !pgf_done),
      .stop(!s_outw),
      .count(cyc(PG_FALL_CYC)), .running(pgf_run), .done(pgf_done)
   );

   // Range reporting is allowed once soft-start has ended and the stage runs.
   assign uv_armed_pg = (state == `BFS_ST_RUN);

   // ==========================================================================
   // Sequencer state
   // ==========================================================================
   always @* begin
      next_state = state;
      case (state)
         `BFS_ST_OFF: begin
            if (ss_start)
               next_state = `BFS_ST_SOFT;
            else if (s_ov && !fault_stop)
               next_state = `BFS_ST_OVWAIT;
         end
         `BFS_ST_SOFT: begin
            if (fault_stop)
               next_state = `BFS_ST_OFF;
            else if (s_ov)
               next_state = `BFS_ST_OVHOLD;
            else if (ss_done)
               next_state = `BFS_ST_RUN;
         end
         `BFS_ST_RUN: begin
            if (fault_stop)
               next_state = `BFS_ST_OFF;
            else if (s_ov)
               next_state = `BFS_ST_OVHOLD;
            else if (uv_done)
               next_state = `BFS_ST_HICCUP;
         end
         `BFS_ST_OVHOLD: begin
            if (fault_stop)
               next_state = `BFS_ST_OFF;
            else if (s_uv)
               next_state = `BFS_ST_HICCUP;
         end
         `BFS_ST_HICCUP: begin
            if (fault_stop)
               next_state = `BFS_ST_OFF;
            else if (hic_done)
               next_state = s_ov ? `BFS_ST_OVWAIT : `BFS_ST_OFF;
         end
         `BFS_ST_OVWAIT: begin
            if (fault_stop || !s_ov)
               next_state = `BFS_ST_OFF;
         end
         default: next_state = `BFS_ST_OFF;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= `BFS_ST_OFF;
         uv_armed <= 1'b0;
      end else begin
         state <= next_state;
         // Leaving run disarms, but an arm_done pulse in the cycle after the exit re-arms for the next start.
         if (leave_run)
            uv_armed <= 1'b0;
         else if (arm_done)
            uv_armed <= 1'b1;
      end
   end

   // ==========================================================================
   // Gate drive
   // ==========================================================================
   // Low-side release by zero crossing holds until the next on request.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         low_off_cycle <= 1'b0;
      else if (s_on)
         low_off_cycle <= 1'b0;
      else if (s_zc && !s_forced_continuous_conduction)
         low_off_cycle <= 1'b1;
   end

   // In soft-start and run the on request passes through unchanged in either conduction mode.
   always @* begin
      next_hs = 1'b0;
      next_ls = 1'b0;
      case (state)
         `BFS_ST_SOFT, `BFS_ST_RUN: begin
            next_hs = s_on;
            next_ls = !s_on && !low_off_cycle;
         end
         `BFS_ST_OVHOLD: begin
            next_hs = 1'b0;
            next_ls = 1'b1;
         end
         default: begin
            next_hs = 1'b0;
            next_ls = 1'b0;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_side_on         <= 1'b0;
         low_side_on          <= 1'b0;
         output_in_range_flag <= 1'b0;
      end else begin
         high_side_on <= next_hs;
         low_side_on  <= next_ls;
         if (state != `BFS_ST_RUN || pgf_done)
            output_in_range_flag <= 1'b0;
         else if (pgr_done)
            output_in_range_flag <= 1'b1;
      end
   end

   // ==========================================================================
   // Events and interrupt
   // ==========================================================================
   always @* begin
      ev_set = {`BFS_EV_W{1'b0}};
      ev_set[`BFS_EV_UV]      = (state == `BFS_ST_RUN) && uv_done;
      ev_set[`BFS_EV_OV]      = (state != `BFS_ST_OVHOLD) && (next_state == `BFS_ST_OVHOLD);
      ev_set[`BFS_EV_LOCKOUT] = s_lock && (state != `BFS_ST_OFF);
      ev_set[`BFS_EV_THERMAL] = s_temp && (state != `BFS_ST_OFF);
      ev_set[`BFS_EV_PG_RISE] = pgr_done && !output_in_range_flag && (state == `BFS_ST_RUN);
      ev_set[`BFS_EV_PG_FALL] = pgf_done && output_in_range_flag;
   end

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // Write-one-to-clear, but a new event in the same cycle keeps its bit.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_bits <= {`BFS_EV_W{1'b0}};
         mask       <= {`BFS_EV_W{1'b0}};
         enable     <= `BFS_CTRL_RESET;
         irq        <= 1'b0;
      end else begin
         if (wr_en && paddr == `BFS_ADDR_EVENT)
            event_bits <= (event_bits & ~pwdata[`BFS_EV_W-1:0]) | ev_set;
         else
            event_bits <= event_bits | ev_set;
         if (wr_en && paddr == `BFS_ADDR_MASK)
            mask <= pwdata[`BFS_EV_W-1:0];
         if (wr_en && paddr == `BFS_ADDR_CTRL)
            enable <= pwdata[`BFS_CTRL_ENABLE];
         irq <= |(event_bits & mask);
      end
   end

   // ==========================================================================
   // APB slave
   // ==========================================================================
   // Reads are captured in setup so the access phase completes with zero wait.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(paddr == `BFS_ADDR_CTRL || paddr == `BFS_ADDR_STATUS ||
                    paddr == `BFS_ADDR_EVENT || paddr == `BFS_ADDR_MASK);
         if (rd_en) begin
            case (paddr)
               `BFS_ADDR_CTRL:   prdata <= {31'h0, enable};
               `BFS_ADDR_STATUS: prdata <= {24'h0, output_in_range_flag, uv_armed, low_side_on,
                                            high_side_on, 1'b0, state};
               `BFS_ADDR_EVENT:  prdata <= {26'h0, event_bits};
               `BFS_ADDR_MASK:   prdata <= {26'h0, mask};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// ==== bfs_sequencer_assertions.sv ====
// Concurrent port checks of the buck fault sequencer, bound into the design.
module bfs_sequencer_chk #(
   parameter int PG_RISE_CYC = 8,
   parameter int PG_FALL_CYC = 4
) (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic [11:0] paddr,
   input logic        pready,
   input logic        pslverr,
   input logic        fb_over,
   input logic        supply_lockout,
   input logic        over_temp,
   input logic        zero_current,
   input logic        on_request,
   input logic        fb_in_window,
   input logic        fb_out_window,
   input logic        forced_continuous_conduction,
   input logic        high_side_on,
   input logic        low_side_on,
   input logic        output_in_range_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [19:0] in_cnt;
   logic [19:0] out_cnt;

   // ==========================================================================
   // Window dwell counters
   // They saturate, so a long dwell in one window never wraps back to a small count.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_cnt <= 20'h0;
         out_cnt <= 20'h0;
      end else begin
         in_cnt <= fb_in_window ? in_cnt + {19'h0, ~&in_cnt} : 20'h0;
         out_cnt <= fb_out_window ? out_cnt + {19'h0, ~&out_cnt} : 20'h0;
      end
   end

   // ==========================================================================
   // Properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   // Auto-skip idle span: inductor current at zero with no on request and no overvoltage.
   sequence s_zero_idle;
      !forced_continuous_conduction && zero_current && !on_request && !fb_over;
   endsequence

   // The margin of four cycles covers input synchronisation and the registered flag.
   AST_PREADY_ACCESS: assert property (s_setup ##1 s_access |-> pready)
      else $error("pready missing in access phase");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_SLVERR_UNMAPPED: assert property (pslverr |-> pready && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
      else $error("pslverr on a mapped address");
   AST_LOCKOUT_OFF: assert property (supply_lockout [*6] |-> !high_side_on && !low_side_on)
      else $error("drivers on during supply lockout");
   AST_THERMAL_OFF: assert property (over_temp [*6] |-> !high_side_on && !low_side_on)
      else $error("drivers on while hot");
   AST_OV_HS_OFF: assert property (fb_over [*6] |-> !high_side_on)
      else $error("high side on during overvoltage");
   AST_ZERO_CROSS_OFF: assert property (s_zero_idle [*6] |-> !low_side_on)
      else $error("low side kept on after zero current");
   AST_RANGE_RISE: assert property ($rose(output_in_range_flag) |-> in_cnt >= PG_RISE_CYC)
      else $error("range flag rose too early");
   AST_RANGE_FALL: assert property (out_cnt > PG_FALL_CYC + 4 |-> !output_in_range_flag)
      else $error("range flag held after leaving window");
endmodule

bind bfs_sequencer bfs_sequencer_chk #(.PG_RISE_CYC(PG_RISE_CYC), .PG_FALL_CYC(PG_FALL_CYC)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .fb_over(fb_over), .supply_lockout(supply_lockout), .over_temp(over_temp),
   .zero_current(zero_current), .on_request(on_request), .fb_in_window(fb_in_window),
   .fb_out_window(fb_out_window), .forced_continuous_conduction(forced_continuous_conduction),
   .high_side_on(high_side_on), .low_side_on(low_side_on), .output_in_range_flag(output_in_range_flag));

// ==== bfs_sync.v ====
// Two-flop synchroniser bank for the comparator and strap inputs.
module bfs_sync #(
   parameter W = 8
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

   reg [W-1:0] stage1;

   // ==========================================================================
   // Synchroniser
   // ==========================================================================
   // The first stage feeds only the second, so metastability never spreads.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ==== bfs_timer.v ====
// Down-counting delay timer with a load strobe and a one-cycle done pulse.
module bfs_timer #(
   parameter W = 20
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         load,
   input  wire         stop,
   input  wire [W-1:0] count,
   output reg          running,
   output reg          done
);

   reg [W-1:0] remain;

   // ==========================================================================
   // Counter
   // ==========================================================================
   // Load wins over stop so a restart in the same cycle is never lost.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remain  <= {W{1'b0}};
         running <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            remain  <= count;
            running <= 1'b1;
         end else if (stop) begin
            running <= 1'b0;
         end else if (running) begin
            if (remain <= {{(W-1){1'b0}}, 1'b1}) begin
               running <= 1'b0;
               done    <= 1'b1;
            end else begin
               remain <= remain - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

// ==== test_bfs_sequencer.sv ====
// Self-checking testbench of the buck fault sequencer.
`include "bfs_consts.vh"
module test_bfs_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int UVD = 4, HIC = 30, ARM = 40, PGR = 8, PGF = 4, SS = 20;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, hs, ls, pg, irq, zc, e;
   logic        uv = 1'h0, ov = 1'h0, lock = 1'h0, hot = 1'h0, onr = 1'h0, win = 1'h1, wout = 1'h0, fcc = 1'h0;
   logic [4:0]  ph = 5'h0;
   int          fail_count = 0, compares = 0, k;

   // ==========================================================================
   // Clock and on-time request, three cycles on in every thirty-two.
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      ph <= ph + 5'h1;
      onr <= ph < 5'h3;
   end

   bfs_sequencer #(.UV_DELAY_CYC(UVD), .HICCUP_CYC(HIC), .UV_ARM_CYC(ARM), .PG_RISE_CYC(PGR),
      .PG_FALL_CYC(PGF), .SS_CYC(SS)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fb_under(uv), .fb_over(ov),
      .supply_lockout(lock), .over_temp(hot), .zero_current(zc), .on_request(onr), .fb_in_window(win),
      .fb_out_window(wout), .forced_continuous_conduction(fcc), .high_side_on(hs), .low_side_on(ls),
      .output_in_range_flag(pg), .irq(irq));
   bfs_power_stage ps (.pclk(pclk), .presetn(presetn), .high_side_on(hs), .low_side_on(ls), .zero_current(zc));

   // ==========================================================================
   // Tasks
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bail(input bit c);
      if (c) begin
         fail_count++;
         tally_and_finish();
      end
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      bail(pready !== 1'h1);
   endtask
   task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         apb(1'h0, `BFS_ADDR_STATUS, 32'h0);
         n++;
      end while ((r & m) !== v && n < 400);
      bail((r & m) !== v);
   endtask
   // Drivers are registered one cycle behind the state, so let them settle first.
   task automatic drv(input logic [31:0] v);
      repeat (2) @(posedge pclk);
      chk("drivers", {hs, ls}, v);
   endtask
   task automatic at_ph(input logic [4:0] v);
      int n;
      n = 0;
      while (ph !== v && n < 64) begin
         @(posedge pclk);
         n++;
      end
      bail(ph !== v);
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `BFS_ADDR_CTRL, 32'h0);
      chk("ctrl reset", r, 32'h1);
      apb(1'h0, `BFS_ADDR_MASK, 32'h0);
      chk("mask reset", r, 32'h0);
      apb(1'h1, 12'h010, 32'hffff_ffff);
      chk("unmapped write error", e, 32'h1);
      apb(1'h0, 12'h010, 32'h0);
      chk("unmapped read data", r, 32'h0);
      chk("unmapped read error", e, 32'h1);
      apb(1'h1, `BFS_ADDR_MASK, 32'h3f);
      wait_st(32'h7, 32'h1);
      chk("range flag in soft-start", pg, 32'h0);
      wait_st(32'h7, 32'h2);
      uv <= 1'h1;
      repeat (20) @(posedge pclk);
      uv <= 1'h0;
      apb(1'h0, `BFS_ADDR_STATUS, 32'h0);
      chk("unarmed state", r & 32'h47, 32'h2);
      $display("test reset and arming done");
      for (int m = 0; m < 2; m++) begin
         fcc <= m[0];
         at_ph(5'h0);
         k = 0;
         repeat (32) begin
            @(posedge pclk);
            k += hs;
         end
         chk("on-time cycles", k, 32'h3);
         at_ph(5'h1c);
         chk("low side after zero current", ls, m);
      end
      fcc <= 1'h0;
      $display("test conduction modes done");
      wait_st(32'h40, 32'h40);
      apb(1'h1, `BFS_ADDR_EVENT, 32'h3f);
      repeat (2) @(posedge pclk);
      chk("irq idle", irq, 32'h0);
      uv <= 1'h1;
      wait_st(32'h7, 32'h4);
      drv(32'h0);
      uv <= 1'h0;
      apb(1'h0, `BFS_ADDR_EVENT, 32'h0);
      chk("uv event", r & 32'h1, 32'h1);
      chk("irq raised", irq, 32'h1);
      repeat (HIC / 2) @(posedge pclk);
      apb(1'h0, `BFS_ADDR_STATUS, 32'h0);
      chk("hiccup wait", r & 32'h7, 32'h4);
      apb(1'h1, `BFS_ADDR_EVENT, 32'h3f);
      repeat (2) @(posedge pclk);
      chk("irq cleared", irq, 32'h0);
      wait_st(32'h7, 32'h2);
      $display("test undervoltage done");
      ov <= 1'h1;
      wait_st(32'h7, 32'h3);
      drv(32'h1);
      uv <= 1'h1;
      wait_st(32'h7, 32'h4);
      drv(32'h0);
      uv <= 1'h0;
      wait_st(32'h7, 32'h5);
      drv(32'h0);
      ov <= 1'h0;
      wait_st(32'h7, 32'h2);
      $display("test overvoltage done");
      for (int i = 0; i < 2; i++) begin
         apb(1'h1, `BFS_ADDR_EVENT, 32'h3f);
         lock <= (i == 0);
         hot <= (i == 1);
         wait_st(32'h7, 32'h0);
         drv(32'h0);
         apb(1'h0, `BFS_ADDR_EVENT, 32'h0);
         chk("shutdown event", (r >> (2 + i)) & 32'h1, 32'h1);
         lock <= 1'h0;
         hot <= 1'h0;
         wait_st(32'h7, 32'h2);
      end
      $display("test lockout and thermal done");
      wait_st(32'h80, 32'h80);
      apb(1'h1, `BFS_ADDR_EVENT, 32'h3f);
      win <= 1'h0;
      wout <= 1'h1;
      wait_st(32'h80, 32'h0);
      apb(1'h0, `BFS_ADDR_EVENT, 32'h0);
      chk("range fall event", r & 32'h20, 32'h20);
      win <= 1'h1;
      wout <= 1'h0;
      k = 0;
      while (pg !== 1'h1 && k < 200) begin
         @(posedge pclk);
         k++;
      end
      chk("range rise delay", k >= PGR, 32'h1);
      chk("range flag risen", pg, 32'h1);
      $display("test range flag done");
      apb(1'h1, `BFS_ADDR_CTRL, 32'h0);
      wait_st(32'h7, 32'h0);
      drv(32'h0);
      apb(1'h1, `BFS_ADDR_CTRL, 32'h1);
      wait_st(32'h7, 32'h2);
      $display("test enable done");
      tally_and_finish();
   end
endmodule
